// >>> src/lcdcd_cfg.svh
// constants of the lcd column driver command decoder: offsets, field positions, reset values
`ifndef LCDCD_CFG_SVH
`define LCDCD_CFG_SVH

// slave address: six fixed upper bits, lsb from the strap
`define LCDCD_ADDR_HI6     6'h1e

// bit slots inside a byte frame
`define LCDCD_LAST_BIT     4'h7
`define LCDCD_ACK_BIT      4'h8

// command byte fields
`define LCDCD_CONT_BIT     7
`define LCDCD_OP_MODE      2'h2
`define LCDCD_OP_DSEL      3'h6
`define LCDCD_OP_RAMAC     3'h7
`define LCDCD_OP_SBANK     5'h1f
`define LCDCD_AMODE_BAD    2'h3

// layout of the configuration word handed to the reference domain
`define LCDCD_CFG_W        9
`define LCDCD_CFG_MUX_LSB  0
`define LCDCD_CFG_STAT_LSB 2
`define LCDCD_CFG_TYPE_BIT 4
`define LCDCD_CFG_TBNK_LSB 5
`define LCDCD_CFG_AMOD_LSB 7

// power-on values
`define LCDCD_MUX_RST      2'h0
`define LCDCD_STAT_RST     2'h0
`define LCDCD_TYPE_RST     1'h0
`define LCDCD_TBNK_RST     2'h0
`define LCDCD_AMOD_RST     2'h0
`define LCDCD_CFG_RST      9'h000
`define LCDCD_COL_RST      6'h00
`define LCDCD_BANK_RST     2'h0
`define LCDCD_SUB_RST      4'h0

// ram geometry
`define LCDCD_NCOL         40

`endif

// >>> src/lcdcd_pkg.sv
// types of the lcd column driver command decoder
package lcdcd_pkg;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ADDR  = 6'h02,
    ST_CMD   = 6'h04,
    ST_WDATA = 6'h08,
    ST_RDATA = 6'h10,
    ST_SKIP  = 6'h20
  } lcdcd_state_t;

  typedef logic [1:0] lcdcd_mux_t;
  typedef logic [1:0] lcdcd_stat_t;
  typedef logic [1:0] lcdcd_amode_t;
  typedef logic [1:0] lcdcd_bank_t;
  typedef logic [3:0] lcdcd_sub_t;
  typedef logic [5:0] lcdcd_col_t;
  typedef logic [7:0] lcdcd_byte_t;

endpackage

// >>> src/lcdcd_sync2.sv
// two flip-flop level synchroniser, any width
`timescale 1ns/1ps
module lcdcd_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,    // destination clock
  input  wire logic         resetn_i, // async reset, active low
  input  wire logic [W-1:0] d_i,      // level from another domain
  output logic      [W-1:0] q_o       // synchronised level
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  if (W < 1) begin : g_w_chk
    $error("lcdcd_sync2: W must be at least 1");
  end

  // meta_q feeds sync_q only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule // lcdcd_sync2

// >>> src/lcdcd_top.sv
// two-wire slave front end and command decoder of an lcd column driver
`timescale 1ns/1ps
`include "lcdcd_cfg.svh"

module lcdcd_top #(
  parameter int NCOL = `LCDCD_NCOL
) (
  input  wire logic                 ref_clk_i,         // system clock, 100 MHz
  input  wire logic                 resetn_i,          // async reset, active low
  input  wire logic                 scl_i,             // bus clock, clocks the link logic
  input  wire logic                 sda_i,             // bus data level
  output logic                      sda_o,             // data driven level, always low
  output logic                      sda_oe_o,          // high while pulling data low
  input  wire logic                 addr_lsb_strap_i,  // strap: slave address lsb
  input  wire lcdcd_pkg::lcdcd_sub_t hw_subaddr_pins_i, // strap: hardware subaddress
  output logic                      ram_we_o,          // ram write strobe, scl domain
  output lcdcd_pkg::lcdcd_col_t     ram_col_o,         // ram column address
  output lcdcd_pkg::lcdcd_bank_t    ram_bank_o,        // ram bank address
  output lcdcd_pkg::lcdcd_byte_t    ram_wdata_o,       // ram write data
  input  wire lcdcd_pkg::lcdcd_byte_t ram_rdata_i,     // ram read data at ram address
  output lcdcd_pkg::lcdcd_sub_t     subaddr_cnt_o,     // subaddress counter, scl domain
  output lcdcd_pkg::lcdcd_mux_t     mux_rate_o,        // multiplex rate field
  output lcdcd_pkg::lcdcd_stat_t    disp_status_o,     // display status field
  output logic                      sys_type_o,        // system type bit
  output lcdcd_pkg::lcdcd_bank_t    top_bank_o,        // bank at display top
  output lcdcd_pkg::lcdcd_amode_t   access_mode_o      // ram access mode
);
  import lcdcd_pkg::*;

  // a six-bit pointer serves at most 64 columns
  if (NCOL < 1 || NCOL > 64) begin : g_ncol_chk
    $error("lcdcd_top: NCOL must lie in 1..64");
  end

  localparam lcdcd_col_t LAST_COL = lcdcd_col_t'(NCOL - 1);

  // link state, scl domain
  lcdcd_state_t state_q;
  logic [3:0]   bit_cnt_q;
  logic [6:0]   rx_q;
  logic         ack_pend_q;
  logic         start_seen_q;
  lcdcd_col_t   col_q;
  lcdcd_bank_t  bank_q;
  lcdcd_sub_t   sub_q;
  logic         ram_we_q;
  lcdcd_col_t   ram_col_q;
  lcdcd_bank_t  ram_bank_q;
  lcdcd_byte_t  ram_wdata_q;
  lcdcd_byte_t  tx_q;
  logic         tx_en_q;
  logic         sda_oe_q;

  // start detector, clocked by the data line itself
  logic         start_tgl_q;

  logic [4:0]   strap_s;
  lcdcd_byte_t  rx_byte;
  logic         byte_done;
  logic         ack_slot;
  logic         start_pend;
  logic         sub_match;
  lcdcd_col_t   col_nx;
  lcdcd_sub_t   sub_nx;
  logic         is_mode;
  logic         is_sbank;
  logic         is_ramac;
  logic         is_dsel;
  logic         is_col;
  logic         cfg_load;
  logic [`LCDCD_CFG_W-1:0] cfg_now;
  logic [`LCDCD_CFG_W-1:0] cfg_d;
  logic [`LCDCD_CFG_W-1:0] cfg_ref;

  // a start is sda falling while scl high; the toggle is settled long before the first scl rise
  always_ff @(negedge sda_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_tgl_q <= 1'h0;
    end else if (scl_i) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  lcdcd_sync2 #(.W(5)) u_strap_sync (
    .clk_i    (scl_i),
    .resetn_i (resetn_i),
    .d_i      ({addr_lsb_strap_i, hw_subaddr_pins_i}),
    .q_o      (strap_s)
  );

  assign start_pend = (start_tgl_q != start_seen_q);
  assign rx_byte    = {rx_q, sda_i};
  assign byte_done  = (bit_cnt_q == `LCDCD_LAST_BIT);
  assign ack_slot   = (bit_cnt_q == `LCDCD_ACK_BIT);
  assign sub_match  = (sub_q == strap_s[3:0]);

  // auto-increment: column first, then next device; counter wraps at 15
  always_comb begin
    col_nx = col_q + 6'h01;
    sub_nx = sub_q;
    if (col_q >= LAST_COL) begin
      col_nx = `LCDCD_COL_RST;
      sub_nx = sub_q + 4'h1;
    end
  end

  // command decode; start bank outranks ram access on shared opcode space
  always_comb begin
    is_col   = !rx_byte[6];
    is_mode  = (rx_byte[6:5] == `LCDCD_OP_MODE);
    is_dsel  = (rx_byte[6:4] == `LCDCD_OP_DSEL);
    is_sbank = (rx_byte[6:2] == `LCDCD_OP_SBANK);
    is_ramac = (rx_byte[6:4] == `LCDCD_OP_RAMAC) && (rx_byte[3:2] != `LCDCD_AMODE_BAD);
  end

  always_comb begin
    cfg_d = cfg_now;
    if (is_mode) begin
      cfg_d[`LCDCD_CFG_MUX_LSB +: 2]  = rx_byte[1:0];
      cfg_d[`LCDCD_CFG_STAT_LSB +: 2] = rx_byte[3:2];
      cfg_d[`LCDCD_CFG_TYPE_BIT]      = rx_byte[4];
    end
    if (is_sbank) begin
      cfg_d[`LCDCD_CFG_TBNK_LSB +: 2] = rx_byte[1:0];
    end
    if (is_ramac) begin
      cfg_d[`LCDCD_CFG_AMOD_LSB +: 2] = rx_byte[3:2];
    end
  end

  assign cfg_load = !start_pend && (state_q == ST_CMD) && byte_done && (is_mode || is_sbank || is_ramac);

  // display settings live in the crossing's hold register and are mirrored into the reference domain
  lcdcd_xfer #(.W(`LCDCD_CFG_W), .RST(`LCDCD_CFG_RST)) u_cfg_xfer (
    .src_clk_i  (scl_i),
    .dst_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .src_load_i (cfg_load),
    .src_data_i (cfg_d),
    .src_q_o    (cfg_now),
    .dst_q_o    (cfg_ref)
  );

  // bit framing and transfer phase, sampled on scl rise
  always_ff @(posedge scl_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q      <= ST_IDLE;
      bit_cnt_q    <= 4'h0;
      rx_q         <= 7'h00;
      ack_pend_q   <= 1'h0;
      start_seen_q <= 1'h0;
    end else begin
      start_seen_q <= start_tgl_q;
      if (start_pend) begin
        state_q    <= ST_ADDR;
        bit_cnt_q  <= 4'h1;
        rx_q       <= {6'h00, sda_i};
        ack_pend_q <= 1'h0;
      end else if (ack_slot) begin
        bit_cnt_q  <= 4'h0;
        ack_pend_q <= 1'h0;
        if (state_q == ST_RDATA && !ack_pend_q && sda_i) begin
          state_q <= ST_SKIP;
        end
      end else if (state_q != ST_IDLE) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        rx_q      <= rx_byte[6:0];
        if (byte_done) begin
          unique case (state_q)
            ST_ADDR: begin
              if (rx_byte[7:1] == {`LCDCD_ADDR_HI6, strap_s[4]}) begin
                ack_pend_q <= 1'h1;
                state_q    <= rx_byte[0] ? ST_RDATA : ST_CMD;
              end else begin
                state_q <= ST_SKIP;
              end
            end
            ST_CMD: begin
              ack_pend_q <= 1'h1;
              state_q    <= rx_byte[`LCDCD_CONT_BIT] ? ST_CMD : ST_WDATA;
            end
            ST_WDATA: begin
              ack_pend_q <= sub_match;
            end
            ST_RDATA: begin
              ack_pend_q <= 1'h0;
            end
            ST_SKIP: begin
              ack_pend_q <= 1'h0;
            end
            ST_IDLE: begin
              ack_pend_q <= 1'h0;
            end
          endcase
        end
      end
    end
  end

  // pointer, subaddress counter and ram port
  always_ff @(posedge scl_i or negedge resetn_i) begin
    if (!resetn_i) begin
      col_q       <= `LCDCD_COL_RST;
      bank_q      <= `LCDCD_BANK_RST;
      sub_q       <= `LCDCD_SUB_RST;
      ram_we_q    <= 1'h0;
      ram_col_q   <= `LCDCD_COL_RST;
      ram_bank_q  <= `LCDCD_BANK_RST;
      ram_wdata_q <= 8'h00;
      tx_q        <= 8'hff;
      tx_en_q     <= 1'h0;
    end else begin
      ram_we_q <= 1'h0;
      if (!start_pend && byte_done) begin
        unique case (state_q)
          ST_ADDR: begin
            // prefetch address so read data is ready at the ack rise
            ram_col_q  <= col_q;
            ram_bank_q <= bank_q;
          end
          ST_CMD: begin
            if (is_col) begin
              col_q <= rx_byte[5:0];
            end
            if (is_dsel) begin
              sub_q <= rx_byte[3:0];
            end
            if (is_ramac) begin
              bank_q <= rx_byte[1:0];
            end
          end
          ST_WDATA: begin
            ram_we_q    <= sub_match;
            ram_wdata_q <= rx_byte;
            ram_col_q   <= col_q;
            ram_bank_q  <= bank_q;
            col_q       <= col_nx;
            sub_q       <= sub_nx;
          end
          ST_RDATA: begin
            tx_en_q <= 1'h0;
          end
          ST_SKIP: begin
            tx_en_q <= 1'h0;
          end
          ST_IDLE: begin
            tx_en_q <= 1'h0;
          end
        endcase
      end
      // load next read byte on the address ack or on a master ack
      if (!start_pend && ack_slot && state_q == ST_RDATA && (ack_pend_q || !sda_i)) begin
        tx_q       <= ram_rdata_i;
        tx_en_q    <= sub_match;
        col_q      <= col_nx;
        sub_q      <= sub_nx;
        ram_col_q  <= col_nx;
        ram_bank_q <= bank_q;
      end
    end
  end

  // data line changes only while scl is low
  always_ff @(negedge scl_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sda_oe_q <= 1'h0;
    end else if (ack_slot) begin
      sda_oe_q <= ack_pend_q;
    end else if (state_q == ST_RDATA && bit_cnt_q < `LCDCD_ACK_BIT) begin
      sda_oe_q <= tx_en_q && !tx_q[3'(4'h7 - bit_cnt_q)];
    end else begin
      sda_oe_q <= 1'h0;
    end
  end

  assign sda_o         = 1'h0;
  assign sda_oe_o      = sda_oe_q;
  assign ram_we_o      = ram_we_q;
  assign ram_col_o     = ram_col_q;
  assign ram_bank_o    = ram_bank_q;
  assign ram_wdata_o   = ram_wdata_q;
  assign subaddr_cnt_o = sub_q;
  assign mux_rate_o    = cfg_ref[`LCDCD_CFG_MUX_LSB +: 2];
  assign disp_status_o = cfg_ref[`LCDCD_CFG_STAT_LSB +: 2];
  assign sys_type_o    = cfg_ref[`LCDCD_CFG_TYPE_BIT];
  assign top_bank_o    = cfg_ref[`LCDCD_CFG_TBNK_LSB +: 2];
  assign access_mode_o = cfg_ref[`LCDCD_CFG_AMOD_LSB +: 2];

endmodule // lcdcd_top

// >>> src/lcdcd_xfer.sv
// word crossing by toggle: source holds the word, destination reloads on each toggle
`timescale 1ns/1ps
module lcdcd_xfer #(
  parameter int           W   = 9,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         src_clk_i,  // source clock
  input  wire logic         dst_clk_i,  // destination clock
  input  wire logic         resetn_i,   // async reset, active low
  input  wire logic         src_load_i, // source strobe, one source cycle
  input  wire logic [W-1:0] src_data_i, // new word
  output logic      [W-1:0] src_q_o,    // word held in source domain
  output logic      [W-1:0] dst_q_o     // word in destination domain
);

  logic [W-1:0] hold_q;
  logic         tgl_q;
  logic         tgl_s;
  logic         seen_q;
  logic [W-1:0] dst_q;

  if (W < 1) begin : g_w_chk
    $error("lcdcd_xfer: W must be at least 1");
  end

  // hold_q is stable for many source cycles between loads, so it is safe to read once the toggle arrives
  always_ff @(posedge src_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_q <= RST;
      tgl_q  <= 1'h0;
    end else if (src_load_i) begin
      hold_q <= src_data_i;
      tgl_q  <= ~tgl_q;
    end
  end

  lcdcd_sync2 #(.W(1)) u_tgl_sync (
    .clk_i    (dst_clk_i),
    .resetn_i (resetn_i),
    .d_i      (tgl_q),
    .q_o      (tgl_s)
  );

  always_ff @(posedge dst_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seen_q <= 1'h0;
      dst_q  <= RST;
    end else begin
      seen_q <= tgl_s;
      if (tgl_s != seen_q) begin
        dst_q <= hold_q;
      end
    end
  end

  assign src_q_o = hold_q;
  assign dst_q_o = dst_q;

endmodule // lcdcd_xfer

// >>> tb/lcdcd_chk.sv
// concurrent checks on the link side of the command decoder
`timescale 1ns/1ps
`include "lcdcd_cfg.svh"
module lcdcd_chk #(
  parameter int NCOL = 40
) (
  input wire logic                  scl_i,             // link clock
  input wire logic                  resetn_i,          // async reset, active low
  input wire logic                  sda_i,             // resolved data level
  input wire logic                  sda_oe_o,          // device pulls data low
  input wire logic                  addr_lsb_strap_i,  // address lsb strap
  input wire lcdcd_pkg::lcdcd_sub_t hw_subaddr_pins_i, // subaddress strap
  input wire logic                  ram_we_o,          // ram write strobe
  input wire lcdcd_pkg::lcdcd_col_t ram_col_o,         // ram column
  input wire lcdcd_pkg::lcdcd_sub_t subaddr_cnt_o      // subaddress counter
);
  import lcdcd_pkg::*;
  logic       st_t, st_s, act, rw, cmd, mat, nb, dp, dn;
  logic [3:0] cnt;
  logic [7:0] sh;
  // a start can land at any moment, so it is caught on the data edge
  always_ff @(negedge sda_i or negedge resetn_i) begin
    if (!resetn_i) st_t <= 1'b0;
    else if (scl_i) st_t <= ~st_t;
  end
  always_ff @(posedge scl_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {st_s, act, rw, cmd, mat, nb, dn, cnt, sh} <= '0;
    end else if (st_t != st_s) begin
      {st_s, act, nb, dn, cnt, sh} <= {st_t, 1'b1, 1'b0, 1'b0, 4'h1, 7'h0, sda_i};
    end else if (cnt == 4'h8) begin
      cnt <= 4'h0;
      nb <= 1'b1;
      // first write byte jumps from the prefetch address to the loaded pointer
      dn <= dp;
      if (!nb) {rw, cmd, mat} <= {sh[0], ~sh[0], sh[7:1] == {`LCDCD_ADDR_HI6, addr_lsb_strap_i}};
      else if (!rw) cmd <= cmd & sh[7];
    end else begin
      cnt <= cnt + 4'h1;
      sh <= {sh[6:0], sda_i};
    end
  end
  assign dp = act && mat && !cmd && nb;
  default clocking cb @(posedge scl_i); endclocking
  default disable iff (!resetn_i);
  a_addr_ack:
    assert property (act && !nb && cnt == 4'h8 |-> sda_oe_o == (sh[7:1] == {`LCDCD_ADDR_HI6, addr_lsb_strap_i}))
    else $error("address ack wrong");
  a_cmd_ack:
    assert property (act && mat && nb && cmd && cnt == 4'h8 |-> sda_oe_o) else $error("command not acked");
  a_data_ack:
    assert property (dp && !rw && cnt == 4'h8 |-> sda_oe_o == ($past(subaddr_cnt_o, 2) == hw_subaddr_pins_i))
    else $error("data ack wrong");
  a_we_pulse:
    assert property (ram_we_o |-> act && mat && !rw && !cmd && cnt == 4'h8 ##1 !ram_we_o)
    else $error("write strobe out of place");
  a_we_match:
    assert property ($rose(ram_we_o) |-> $past(subaddr_cnt_o) == hw_subaddr_pins_i) else $error("write without match");
  a_nack_release:
    assert property (dp && rw && cnt == 4'h8 && sda_i |=> !sda_oe_o [*8]) else $error("data held after nack");
  a_sub_step:
    assert property (dp && $changed(subaddr_cnt_o) |-> subaddr_cnt_o == $past(subaddr_cnt_o) + 4'h1)
    else $error("subaddress step wrong");
  a_col_step:
    assert property (dp && (rw || dn) && $changed(ram_col_o) |->
      ram_col_o == (($past(ram_col_o) == 6'(NCOL - 1)) ? 6'h0 : $past(ram_col_o) + 6'h1))
    else $error("column step wrong");
endmodule // lcdcd_chk

bind lcdcd_top lcdcd_chk #(.NCOL(NCOL)) lcdcd_chk_i (.scl_i(scl_i), .resetn_i(resetn_i), .sda_i(sda_i),
  .sda_oe_o(sda_oe_o), .addr_lsb_strap_i(addr_lsb_strap_i), .hw_subaddr_pins_i(hw_subaddr_pins_i),
  .ram_we_o(ram_we_o), .ram_col_o(ram_col_o), .subaddr_cnt_o(subaddr_cnt_o));

// >>> tb/lcdcd_master.sv
// two-wire bus master model; the link clock runs inside frames and in idle() between them
`timescale 1ns/1ps
module lcdcd_master (
  output logic      scl_o,    // link clock, high when idle
  output logic      sda_oe_o, // high while pulling data low
  input  wire logic sda_i     // resolved data level
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // data moves only while the clock is low; sampled at the rise
  task automatic slot(input logic b, output logic s);
    #1 sda_oe_o = ~b;
    #2 s = sda_i;
    scl_o = 1'b1;
    #3 scl_o = 1'b0;
  endtask
  task automatic idle();
    repeat (2) begin
      #3 scl_o = 1'b0;
      #3 scl_o = 1'b1;
    end
  endtask
  task automatic start();
    if (!scl_o) begin
      #1 sda_oe_o = 1'b0;
      #2 scl_o = 1'b1;
    end
    #2 sda_oe_o = 1'b1;
    #3 scl_o = 1'b0;
  endtask
  task automatic stop();
    #1 sda_oe_o = 1'b1;
    #2 scl_o = 1'b1;
    #2 sda_oe_o = 1'b0;
    #3;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(b[i], s);
    slot(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) slot(1'b1, b[i]);
    slot(last, s);
  endtask
endmodule // lcdcd_master

// >>> tb/lcdcd_tb_top.sv
// self-checking bench: transfers through the bus master model
`timescale 1ns/1ps
module lcdcd_tb_top;
  import lcdcd_pkg::*;
  logic         ref_clk_i, resetn_i, strap, scl, m_oe, d_oe, sdao, we, stype, ak;
  lcdcd_sub_t   pins, sub_o;
  lcdcd_col_t   col;
  lcdcd_bank_t  bank, tbank;
  lcdcd_byte_t  wdata, rd, b;
  lcdcd_mux_t   mux;
  lcdcd_stat_t  stat;
  lcdcd_amode_t amode;
  int           error_cnt, checks_done;
  logic [15:0]  wlog[$];
  wire          sda = ~(m_oe | (d_oe & ~sdao)); // pull-up: a released line reads high
  assign rd = {bank, col};
  lcdcd_top #(.NCOL(40)) lcdcd_top_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sdao), .sda_oe_o(d_oe), .addr_lsb_strap_i(strap), .hw_subaddr_pins_i(pins), .ram_we_o(we),
    .ram_col_o(col), .ram_bank_o(bank), .ram_wdata_o(wdata), .ram_rdata_i(rd), .subaddr_cnt_o(sub_o),
    .mux_rate_o(mux), .disp_status_o(stat), .sys_type_o(stype), .top_bank_o(tbank), .access_mode_o(amode));
  lcdcd_master lcdcd_master_i (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // strobe is still high at the fall between data bit 8 and the ack rise
  always @(negedge scl) if (we === 1'b1) wlog.push_back({bank, col, wdata});
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  task automatic send(input lcdcd_byte_t q[$], input logic [15:0] m);
    @(posedge ref_clk_i) #1;
    lcdcd_master_i.start();
    foreach (q[i]) begin
      lcdcd_master_i.wbyte(q[i], ak);
      chk("ack", {7'h0, m[i]}, {7'h0, ak});
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt++;
    end_sim();
  end
  initial begin
    resetn_i = 1'b0;
    strap = 1'b1;
    pins = 4'h3;
    error_cnt = 0;
    checks_done = 0;
    lcdcd_master_i.idle();
    repeat (20) @(posedge ref_clk_i);
    #1 resetn_i = 1'b1;
    chk("cfg", 8'h0, {mux, stat, stype, tbank, 1'b0});
    chk("ptr", 8'h0, {bank, col});
    chk("sub", 8'h0, {2'h0, amode, sub_o});
    $display("test reset done");
    for (int s = 0; s < 2; s++) begin
      strap = s[0];
      lcdcd_master_i.idle();
      for (int a = 0; a < 2; a++) begin
        send('{{6'h1e, a[0], 1'b0}, 8'h20}, {14'h0, {2{a == s}}});
        lcdcd_master_i.stop();
      end
    end
    $display("test address done");
    for (int i = 0; i < 4; i++) begin
      send('{8'h7a, {3'h6, i[0], 2'(3 - i), 2'(i)}, {6'h3f, 2'(i)}, {4'hf, 2'(i % 3), 2'(i)},
             {2'h0, 6'(i + 36)}}, 16'h001f);
      // ram address shows the pointer only once an address byte has fetched it
      send('{8'h7b}, 16'h0001);
      lcdcd_master_i.stop();
      repeat (8) @(posedge ref_clk_i);
      chk("mode", {2'(i), 2'(3 - i), i[0], 2'(i), 1'b0}, {mux, stat, stype, tbank, 1'b0});
      chk("access", {2'(i % 3), 2'(i), 4'h0}, {amode, bank, 4'h0});
      // the read address ack has already stepped the pointer once
      chk("column", 8'((i + 37) % 40), 8'(col));
    end
    $display("test commands done");
    wlog.delete();
    send('{8'h7a, 8'he3, 8'hf2, 8'h26, 8'hc5, 8'h11, 8'h22, 8'h33}, 16'h003f);
    lcdcd_master_i.stop();
    repeat (8) @(posedge ref_clk_i);
    chk("writes", 8'h2, 8'(wlog.size()));
    foreach (wlog[k]) begin
      chk("wr ptr", {2'h2, 6'(38 + k)}, wlog[k][15:8]);
      chk("wr data", k ? 8'h11 : 8'hc5, wlog[k][7:0]);
    end
    chk("sub", 8'h4, 8'(sub_o));
    chk("data not cmd", 8'h3, 8'(mux));
    send('{8'h7a, 8'hef, 8'h27, 8'h44}, 16'h0007);
    lcdcd_master_i.stop();
    chk("wrap", 8'h0, 8'(sub_o));
    chk("writes", 8'h2, 8'(wlog.size()));
    $display("test write done");
    send('{8'h7a, 8'he3, 8'hf1, 8'h05}, 16'h000f);
    send('{8'h7b}, 16'h0001);
    for (int k = 0; k < 3; k++) begin
      lcdcd_master_i.rbyte(k == 2, b);
      chk("read", {2'h1, 6'(5 + k)}, b);
    end
    #1 chk("released", 8'h0, 8'(d_oe));
    lcdcd_master_i.stop();
    $display("test read done");
    send('{8'h7a, 8'h00, 8'h55}, 16'h0007);
    send('{8'h7a, 8'h59}, 16'h0003);
    lcdcd_master_i.stop();
    repeat (8) @(posedge ref_clk_i);
    chk("restart", {3'h0, 2'h1, 2'h2, 1'b1}, 8'({mux, stat, stype}));
    $display("test restart done");
    end_sim();
  end
endmodule // lcdcd_tb_top
